// >>> mec_codec.v
// Host-side builder and parser for four MAC information elements, Wishbone controlled
//
// Design decisions made here: the Wishbone register port and the placing of the registers.
`include "mec_consts.vh"

module mec_codec #(
  parameter REP_MAX = 4,
  parameter LVL_AW = 9
) (
  input wire clk,
  input wire rst_b,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [31:0] wb_dat_i,
  input wire [3:0] wb_sel_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  output reg [7:0] tx_data,
  output reg tx_valid,
  output reg tx_last,
  input wire tx_ready,
  input wire [7:0] rx_data,
  input wire rx_valid,
  input wire rx_last
);

  // Transmit and receive sequencer states
  localparam S_IDLE = 2'h0;
  localparam S_FIX = 2'h1;
  localparam S_RBM = 2'h2;
  localparam S_RLV = 2'h3;
  localparam R_ID = 3'h0;
  localparam R_LEN = 3'h1;
  localparam R_FIX = 3'h2;
  localparam R_MHDR = 3'h3;
  localparam R_RBM = 3'h4;
  localparam R_RLV = 3'h5;
  localparam R_SKIP = 3'h6;

  // Set bits in a 16-bit bitmap
  function [4:0] mec_pop;
    input [15:0] v;
    integer k;
    begin
      mec_pop = 5'h00;
      for (k = 0; k < 16; k = k + 1) begin
        mec_pop = mec_pop + {4'h0, v[k]};
      end
    end
  endfunction

  // Level codes carried by one report; both maps empty means one scan average
  function [8:0] mec_nlvl;
    input [15:0] z;
    input [15:0] s;
    reg [9:0] p;
    begin
      p = mec_pop(z) * mec_pop(s);
      if (z == 16'h0000 && s == 16'h0000) begin
        mec_nlvl = 9'h001;
      end else begin
        mec_nlvl = p[8:0];
      end
    end
  endfunction

  // Octets of level codes, odd count padded with a zero nibble
  function [8:0] mec_lvl_oct;
    input [8:0] n;
    reg [9:0] t;
    begin
      t = {1'b0, n} + 10'h001;
      mec_lvl_oct = t[9:1];
    end
  endfunction

  // Software-visible registers
  reg [31:0] txf0_q; // Fixed element fields
  reg [10:0] txf1_q; // Beam and report count
  reg [1:0] repsel_q; // Report selector
  reg [1:0] kind_q; // Element being sent
  reg [31:0] bmp_q [0:REP_MAX-1]; // {slot map, zone map} per outgoing report
  reg [3:0] lvl_mem [0:(1<<LVL_AW)-1]; // Outgoing level codes, report after report
  reg [LVL_AW-1:0] rxlvl_idx_q; // Read pointer into received levels
  reg go_err_q; // Last start refused for length or report count
  // Sequencers
  reg [1:0] st_q;
  reg [2:0] idx_q; // Octet within fixed part or bitmaps
  reg [1:0] rep_q; // Report being sent
  reg [8:0] left_q; // Level codes still to send in this report
  reg [LVL_AW-1:0] ptr_q; // Level memory read pointer
  reg [9:0] mlen; // Computed measurement length

  // Measurement length: two header octets plus every report
  always @* begin : mlen_calc
    integer r;
    reg [31:0] b;
    mlen = {1'b0, `MEC_LEN_MEAS_HDR};
    b = 32'h0;
    for (r = 0; r < REP_MAX; r = r + 1) begin
      b = bmp_q[r];
      if (r < txf1_q[10:8]) begin
        mlen = mlen + {1'b0, `MEC_REP_BMP_OCT}
               + {1'b0, mec_lvl_oct(mec_nlvl(b[15:0], b[31:16]))};
      end
    end
  end

  wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wb_wr = wb_req & wb_we_i & (&wb_sel_i); // Only whole-word writes land
  wire go = wb_wr && wb_adr_i == `MEC_R_CTRL && wb_dat_i[`MEC_C_GO] && st_q == S_IDLE;
  wire [1:0] go_kind = wb_dat_i[`MEC_C_KIND_HI:`MEC_C_KIND_LO];
  wire go_bad = go_kind == `MEC_K_MEAS && (mlen > 10'h0ff || txf1_q[10:8] == 3'h0
                || txf1_q[10:8] > REP_MAX);
  wire adv = ~tx_valid | tx_ready; // Output slot free this cycle

  // Fixed-part octet for the kind being sent
  reg [7:0] fix_oct;
  reg fix_end;
  always @* begin
    fix_oct = 8'h00;
    fix_end = 1'b0;
    case (kind_q)
      `MEC_K_SWITCH: begin
        case (idx_q)
          3'h0: fix_oct = `MEC_ID_SWITCH;
          3'h1: fix_oct = `MEC_LEN_SWITCH;
          3'h2: fix_oct = txf0_q[7:0];
          3'h3: fix_oct = txf0_q[15:8];
          3'h4: fix_oct = txf0_q[23:16];
          default: fix_oct = txf0_q[31:24];
        endcase
        fix_end = idx_q == 3'h5;
      end
      `MEC_K_BOND: begin
        case (idx_q)
          3'h0: fix_oct = `MEC_ID_BOND;
          3'h1: fix_oct = `MEC_LEN_BOND;
          3'h2: fix_oct = txf0_q[7:0];
          3'h3: fix_oct = txf0_q[15:8];
          // Status, zero reserved bit, reason, band map
          default: fix_oct = {txf0_q[16], 1'b0,
                              txf0_q[18:17], txf0_q[22:19]};
        endcase
        fix_end = idx_q == 3'h4;
      end
      `MEC_K_CHCHG: begin
        case (idx_q)
          3'h0: fix_oct = `MEC_ID_CHCHG;
          3'h1: fix_oct = `MEC_LEN_CHCHG;
          3'h2: fix_oct = txf0_q[7:0];
          default: fix_oct = txf0_q[15:8];
        endcase
        fix_end = idx_q == 3'h3;
      end
      default: begin
        case (idx_q)
          3'h0: fix_oct = `MEC_ID_MEAS;
          3'h1: fix_oct = mlen[7:0];
          3'h2: fix_oct = txf1_q[7:0];
          default: fix_oct = {5'h00, txf1_q[10:8]};
        endcase
        fix_end = idx_q == 3'h3;
      end
    endcase
  end

  // Software register writes
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      txf0_q <= 32'h0;
      txf1_q <= 11'h001;
      repsel_q <= 2'h0;
      rxlvl_idx_q <= {LVL_AW{1'b0}};
      go_err_q <= 1'b0;
    end else if (wb_wr) begin
      case (wb_adr_i)
        `MEC_R_TXF0: txf0_q <= wb_dat_i;
        `MEC_R_TXF1: txf1_q <= wb_dat_i[10:0];
        `MEC_R_REPSEL: repsel_q <= wb_dat_i[1:0];
        `MEC_R_RXLVL: rxlvl_idx_q <= wb_dat_i[LVL_AW-1:0];
        `MEC_R_CTRL: go_err_q <= go & go_bad;
        default: begin
        end
      endcase
    end
  end

  // Report bitmaps and level codes have no reset; software loads them before a start
  always @(posedge clk) begin
    if (wb_wr && wb_adr_i == `MEC_R_REPBMP) begin
      bmp_q[repsel_q] <= wb_dat_i;
    end
    if (wb_wr && wb_adr_i == `MEC_R_LVLWR) begin
      lvl_mem[wb_dat_i[LVL_AW+3:4]] <= wb_dat_i[3:0];
    end
  end

  // Transmit sequencer: one octet per accepted beat, held until tx_ready
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= S_IDLE;
      kind_q <= `MEC_K_SWITCH;
      idx_q <= 3'h0;
      rep_q <= 2'h0;
      left_q <= 9'h000;
      ptr_q <= {LVL_AW{1'b0}};
      tx_data <= 8'h00;
      tx_valid <= 1'b0;
      tx_last <= 1'b0;
    end else begin
      case (st_q)
        S_IDLE: begin
          if (adv) begin
            tx_valid <= 1'b0;
            tx_last <= 1'b0;
          end
          if (go && !go_bad) begin
            kind_q <= go_kind;
            idx_q <= 3'h0;
            rep_q <= 2'h0;
            ptr_q <= {LVL_AW{1'b0}};
            st_q <= S_FIX;
          end
        end
        S_FIX: begin
          if (adv) begin
            tx_data <= fix_oct;
            tx_valid <= 1'b1;
            tx_last <= fix_end && kind_q != `MEC_K_MEAS;
            idx_q <= idx_q + 3'h1;
            if (fix_end) begin
              idx_q <= 3'h0;
              st_q <= kind_q == `MEC_K_MEAS ? S_RBM : S_IDLE;
            end
          end
        end
        S_RBM: begin
          if (adv) begin
            // Zone map then slot map, each low octet first
            tx_data <= bmp_q[rep_q][idx_q[1:0]*8 +: 8];
            tx_valid <= 1'b1;
            tx_last <= 1'b0;
            idx_q <= idx_q + 3'h1;
            if (idx_q == 3'h3) begin
              left_q <= mec_nlvl(bmp_q[rep_q][15:0], bmp_q[rep_q][31:16]);
              st_q <= S_RLV;
            end
          end
        end
        default: begin
          if (adv) begin
            // Earlier slot in the low nibble; a lone last code gets a zero pad
            if (left_q == 9'h001) begin
              tx_data <= {4'h0, lvl_mem[ptr_q]};
              ptr_q <= ptr_q + {{(LVL_AW-1){1'b0}}, 1'b1};
            end else begin
              tx_data <= {lvl_mem[ptr_q + {{(LVL_AW-1){1'b0}}, 1'b1}], lvl_mem[ptr_q]};
              ptr_q <= ptr_q + {{(LVL_AW-2){1'b0}}, 2'h2};
            end
            tx_valid <= 1'b1;
            if (left_q <= 9'h002) begin
              left_q <= 9'h000;
              idx_q <= 3'h0;
              rep_q <= rep_q + 2'h1;
              tx_last <= {1'b0, rep_q} + 3'h1 == txf1_q[10:8];
              st_q <= ({1'b0, rep_q} + 3'h1 == txf1_q[10:8]) ? S_IDLE : S_RBM;
            end else begin
              left_q <= left_q - 9'h002;
              tx_last <= 1'b0;
            end
          end
        end
      endcase
    end
  end

  // Receive parser state
  reg [2:0] rs_q;
  reg [1:0] rkind_q; // Kind of element being parsed
  reg [7:0] rlen_q; // Received length octet
  reg [7:0] rcnt_q; // Body octets seen after the length
  reg [2:0] ridx_q; // Octet within fixed body or bitmaps
  reg [2:0] rrep_q; // Reports fully parsed
  reg [8:0] rleft_q; // Level octets still expected in this report
  reg [LVL_AW-1:0] rptr_q; // Write pointer for received levels
  reg [31:0] rxf0_q; // Parsed fixed fields, TXF0 layout except the bonding control octet, kept raw in bits 23:16
  reg [10:0] rxf1_q; // Parsed beam and report count
  reg [31:0] rbmp_q [0:REP_MAX-1]; // Parsed report bitmaps
  reg [3:0] rlvl_mem [0:(1<<LVL_AW)-1]; // Parsed level codes
  reg rdone_q; // Sticky: an element was parsed
  reg rbad_q; // Last parsed element was malformed, rewritten each time rdone_q is set
  wire rx_clr = wb_wr && wb_adr_i == `MEC_R_CTRL && wb_dat_i[`MEC_C_RXCLR];
  wire [31:0] rbmp_now = {rx_data, rbmp_q[rrep_q[1:0]][23:0]};
  wire [8:0] rbody_oct = {1'b0, rcnt_q} + 9'h001; // Body octets including this one

  // Fixed lengths per kind
  function [7:0] mec_fixlen;
    input [1:0] k;
    begin
      case (k)
        `MEC_K_SWITCH: mec_fixlen = `MEC_LEN_SWITCH;
        `MEC_K_BOND: mec_fixlen = `MEC_LEN_BOND;
        default: mec_fixlen = `MEC_LEN_CHCHG;
      endcase
    end
  endfunction

  // Level and bitmap writes into the parsed store
  always @(posedge clk) begin
    if (rx_valid && rs_q == R_RLV) begin
      rlvl_mem[rptr_q] <= rx_data[3:0];
      rlvl_mem[rptr_q + {{(LVL_AW-1){1'b0}}, 1'b1}] <= rx_data[7:4];
    end
    if (rx_valid && rs_q == R_RBM) begin
      rbmp_q[rrep_q[1:0]][ridx_q[1:0]*8 +: 8] <= rx_data;
    end
  end

  // Receive parser; a raised flag wins over a clear in the same cycle
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rs_q <= R_ID;
      rkind_q <= `MEC_K_SWITCH;
      rlen_q <= 8'h00;
      rcnt_q <= 8'h00;
      ridx_q <= 3'h0;
      rrep_q <= 3'h0;
      rleft_q <= 9'h000;
      rptr_q <= {LVL_AW{1'b0}};
      rxf0_q <= 32'h0;
      rxf1_q <= 11'h000;
      rdone_q <= 1'b0;
      rbad_q <= 1'b0;
    end else begin
      if (rx_clr) begin
        rdone_q <= 1'b0;
        rbad_q <= 1'b0;
      end
      if (rx_valid) begin
        rcnt_q <= rcnt_q + 8'h01;
        case (rs_q)
          R_ID: begin
            rcnt_q <= 8'h00;
            rkind_q <= rx_data == `MEC_ID_SWITCH ? `MEC_K_SWITCH :
                       rx_data == `MEC_ID_BOND ? `MEC_K_BOND :
                       rx_data == `MEC_ID_CHCHG ? `MEC_K_CHCHG : `MEC_K_MEAS;
            if (rx_data == `MEC_ID_SWITCH || rx_data == `MEC_ID_BOND
                || rx_data == `MEC_ID_CHCHG || rx_data == `MEC_ID_MEAS) begin
              rs_q <= R_LEN;
            end else begin
              rs_q <= R_SKIP; // Foreign element: let it pass
            end
          end
          R_LEN: begin
            rlen_q <= rx_data;
            rcnt_q <= 8'h00;
            ridx_q <= 3'h0;
            rrep_q <= 3'h0;
            rptr_q <= {LVL_AW{1'b0}};
            rs_q <= rkind_q == `MEC_K_MEAS ? R_MHDR : R_FIX;
          end
          R_FIX: begin
            rxf0_q[ridx_q*8 +: 8] <= rx_data;
            ridx_q <= ridx_q + 3'h1;
          end
          R_MHDR: begin
            ridx_q <= ridx_q + 3'h1;
            if (ridx_q == 3'h0) begin
              rxf1_q[7:0] <= rx_data;
            end else begin
              rxf1_q[10:8] <= rx_data[2:0];
              ridx_q <= 3'h0;
              rs_q <= R_RBM;
            end
          end
          R_RBM: begin
            ridx_q <= ridx_q + 3'h1;
            if (ridx_q == 3'h3) begin
              rleft_q <= mec_lvl_oct(mec_nlvl(rbmp_now[15:0], rbmp_now[31:16]));
              rs_q <= R_RLV;
            end
          end
          R_RLV: begin
            rptr_q <= rptr_q + {{(LVL_AW-2){1'b0}}, 2'h2};
            rleft_q <= rleft_q - 9'h001;
            if (rleft_q == 9'h001) begin
              rrep_q <= rrep_q + 3'h1;
              ridx_q <= 3'h0;
              rs_q <= R_RBM;
            end
          end
          default: begin
          end
        endcase
        if (rx_last) begin
          rs_q <= R_ID;
          if (rs_q != R_SKIP && rs_q != R_ID) begin
            rdone_q <= 1'b1;
            // Length octet against the fixed length or the reports actually seen
            if (rs_q == R_LEN) begin
              rbad_q <= 1'b1;
            end else if (rkind_q != `MEC_K_MEAS) begin
              rbad_q <= rlen_q != mec_fixlen(rkind_q) || rbody_oct != {1'b0, rlen_q};
            end else begin
              rbad_q <= rbody_oct != {1'b0, rlen_q} || rs_q != R_RLV || rleft_q != 9'h001
                        || rrep_q + 3'h1 != rxf1_q[10:8];
            end
          end
        end
      end
    end
  end

  // Wishbone read mux, answered one cycle after the request
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= wb_req;
      wb_dat_o <= 32'h0;
      if (wb_req && !wb_we_i) begin
        case (wb_adr_i)
          `MEC_R_CTRL: wb_dat_o <= {24'h0, rkind_q, go_err_q, rbad_q, rdone_q, st_q != S_IDLE,
                                    2'h0};
          `MEC_R_TXF0: wb_dat_o <= txf0_q;
          `MEC_R_TXF1: wb_dat_o <= {21'h0, txf1_q};
          `MEC_R_REPSEL: wb_dat_o <= {30'h0, repsel_q};
          `MEC_R_REPBMP: wb_dat_o <= bmp_q[repsel_q];
          `MEC_R_RXF0: wb_dat_o <= rxf0_q;
          `MEC_R_RXF1: wb_dat_o <= {21'h0, rxf1_q};
          `MEC_R_RXLVL: wb_dat_o <= {28'h0, rlvl_mem[rxlvl_idx_q]};
          `MEC_R_RXBMP: wb_dat_o <= rbmp_q[repsel_q];
          default: wb_dat_o <= 32'h0;
        endcase
      end
    end
  end

endmodule

// >>> mec_consts.vh
// Constants for the MAC element codec: element codes, lengths, field positions, register map
`ifndef MEC_CONSTS_VH
`define MEC_CONSTS_VH

// Element identifiers (values arbitrary, override per system)
`define MEC_ID_SWITCH 8'h31
`define MEC_ID_BOND 8'h32
`define MEC_ID_CHCHG 8'h33
`define MEC_ID_MEAS 8'h34

// Element kinds as selected by software
`define MEC_K_SWITCH 2'h0
`define MEC_K_BOND 2'h1
`define MEC_K_CHCHG 2'h2
`define MEC_K_MEAS 2'h3

// Fixed length octets
`define MEC_LEN_SWITCH 8'h04
`define MEC_LEN_BOND 8'h03
`define MEC_LEN_CHCHG 8'h02
`define MEC_LEN_MEAS_HDR 9'h002
`define MEC_REP_BMP_OCT 9'h004

// Bonding control octet layout
`define MEC_BC_STATUS 7
`define MEC_BC_RSV 6
`define MEC_BC_REASON_HI 5
`define MEC_BC_REASON_LO 4
`define MEC_BC_MAP_HI 3
`define MEC_BC_MAP_LO 0

// Reply reason codes
`define MEC_RSN_ACCEPTED 2'h0
`define MEC_RSN_UNAVAIL 2'h1
`define MEC_RSN_CONFLICT 2'h2
`define MEC_RSN_INVALID 2'h3

// Register byte offsets
`define MEC_R_CTRL 8'h00
`define MEC_R_TXF0 8'h04
`define MEC_R_TXF1 8'h08
`define MEC_R_REPSEL 8'h0c
`define MEC_R_REPBMP 8'h10
`define MEC_R_LVLWR 8'h14
`define MEC_R_RXF0 8'h18
`define MEC_R_RXF1 8'h1c
`define MEC_R_RXLVL 8'h20
`define MEC_R_RXBMP 8'h24

// Control register bits
`define MEC_C_GO 0
`define MEC_C_KIND_HI 2
`define MEC_C_KIND_LO 1
`define MEC_C_RXCLR 3

`endif

// >>> mec_codec_chk.sv
// Concurrent checks on the element codec's bus and transmit octet-stream ports
`include "mec_consts.vh"
module mec_codec_chk #(
  parameter REP_MAX = 4
) (
  input wire clk,
  input wire rst_b,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [31:0] wb_dat_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o,
  input wire [7:0] tx_data,
  input wire tx_valid,
  input wire tx_last,
  input wire tx_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking mec_cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  wire take = tx_valid && tx_ready; // Octet leaves at this edge
  reg [8:0] idx_q; // Octet position inside the outgoing element
  reg [7:0] id_q; // Identifier of the outgoing element
  reg [7:0] len_q; // Length octet of the outgoing element
  // Body length of the short element being sent
  wire [8:0] fix_len = (id_q == `MEC_ID_SWITCH) ? 9'h004 :
                       (id_q == `MEC_ID_BOND) ? 9'h003 : 9'h002;
  // Follow the position inside each element; tx_last restarts the count
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      idx_q <= 9'h000;
      id_q <= 8'h00;
      len_q <= 8'h00;
    end else if (take) begin
      idx_q <= tx_last ? 9'h000 : idx_q + 9'h001;
      if (idx_q == 9'h000)
        id_q <= tx_data;
      if (idx_q == 9'h001)
        len_q <= tx_data;
    end
  end
  ack_resp_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus request not answered in the next cycle");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("acknowledge longer than one cycle");
  dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data not zero outside acknowledge");
  tx_hold_a: assert property (tx_valid && !tx_ready |=>
    tx_valid && $stable(tx_data) && $stable(tx_last))
    else $error("stalled octet changed before it was taken");
  last_valid_a: assert property (tx_last |-> tx_valid)
    else $error("end marker without a valid octet");
  go_start_a: assert property (wb_ack_o && wb_we_i && wb_adr_i == `MEC_R_CTRL && wb_sel_i == 4'hf
    && wb_dat_i[3:0] == 4'h1 && !tx_valid |=> tx_valid && tx_data == `MEC_ID_SWITCH)
    else $error("switch element did not start one cycle after the start write");
  first_id_a: assert property (take && idx_q == 9'h000 |-> tx_data == `MEC_ID_SWITCH
    || tx_data == `MEC_ID_BOND || tx_data == `MEC_ID_CHCHG || tx_data == `MEC_ID_MEAS)
    else $error("element does not open with a known identifier");
  fix_len_a: assert property (take && idx_q == 9'h001 && id_q != `MEC_ID_MEAS |->
    tx_data == fix_len[7:0])
    else $error("fixed length octet wrong");
  fix_last_a: assert property (take && idx_q != 9'h000 && id_q != `MEC_ID_MEAS |->
    tx_last == (idx_q == fix_len + 9'h001))
    else $error("short element ends at the wrong octet");
  meas_last_a: assert property (take && idx_q > 9'h001 && id_q == `MEC_ID_MEAS |->
    tx_last == (idx_q == {1'b0, len_q} + 9'h001))
    else $error("measurement element length disagrees with its end");
  meas_count_a: assert property (take && idx_q == 9'h003 && id_q == `MEC_ID_MEAS |->
    tx_data >= 8'h01 && tx_data <= REP_MAX)
    else $error("report count out of range");
  sw_sent_c: cover property (take && tx_last && id_q == `MEC_ID_SWITCH);
  meas_sent_c: cover property (take && tx_last && id_q == `MEC_ID_MEAS);
  tx_stall_c: cover property (tx_valid && !tx_ready);
endmodule
bind mec_codec mec_codec_chk #(.REP_MAX(REP_MAX)) u_chk (.clk(clk), .rst_b(rst_b),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .tx_data(tx_data), .tx_valid(tx_valid), .tx_last(tx_last), .tx_ready(tx_ready));

// >>> mec_peer.sv
// Peer MAC model: octet sink with stalls and element source
`include "mec_consts.vh"
module mec_peer (
  input wire clk,
  input wire jam,
  output logic tx_ready,
  output logic [7:0] rx_data,
  output logic rx_valid,
  output logic rx_last
);
  timeunit 1ns;
  timeprecision 1ps;
  // Quiet lines at time zero
  initial begin
    tx_ready = 1'b0;
    rx_data = 8'h00;
    rx_valid = 1'b0;
    rx_last = 1'b0;
  end
  // Sink readiness; a stall leaves the octet waiting on the wire
  always @(posedge clk) begin
    tx_ready <= !jam;
  end
  // One octet per cycle; released data shows the inverse so stale values never match
  task put(input [7:0] d, input l);
    begin
      @(posedge clk);
      rx_data <= d;
      rx_valid <= 1'b1;
      rx_last <= l;
      if (l) begin
        @(posedge clk);
        rx_valid <= 1'b0;
        rx_last <= 1'b0;
        rx_data <= ~d;
      end
    end
  endtask
  // Period switch announcement, offset low octet first
  task send_switch(input [7:0] cd, input [7:0] so, input [15:0] off);
    begin
      put(`MEC_ID_SWITCH, 1'b0);
      put(`MEC_LEN_SWITCH, 1'b0);
      put(cd, 1'b0);
      put(so, 1'b0);
      put(off[7:0], 1'b0);
      put(off[15:8], 1'b1);
    end
  endtask
  // Report of a channel with no superframe: zero maps and one averaged level
  task send_meas0(input [7:0] beam, input [3:0] lvl);
    begin
      put(`MEC_ID_MEAS, 1'b0);
      put(8'h07, 1'b0);
      put(beam, 1'b0);
      put(8'h01, 1'b0);
      repeat (4) put(8'h00, 1'b0);
      put({4'h0, lvl}, 1'b1);
    end
  endtask
endmodule

// >>> mec_tb.sv
// Self-checking bench for the element codec against the peer MAC model
`include "mec_consts.vh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk;
  logic rst_b;
  logic wb_cyc_i;
  logic wb_stb_i;
  logic wb_we_i;
  logic [7:0] wb_adr_i;
  logic [31:0] wb_dat_i;
  logic [3:0] wb_sel_i;
  wire [31:0] wb_dat_o;
  wire wb_ack_o, tx_valid, tx_last, tx_ready, rx_valid, rx_last;
  wire [7:0] tx_data, rx_data;
  logic slow = 1'b0; // Peer stalls at random when set
  logic jam = 1'b0; // Stall request handed to the peer
  integer seed = 52840;
  integer failures = 0;
  integer comparisons = 0;
  integer i;
  logic [31:0] r; // Random field values
  logic [31:0] q; // Scratch read data
  logic [31:0] rd_q[$]; // Expected read data, oldest first
  logic [8:0] tx_q[$]; // Expected {last, octet}, oldest first
  mec_codec dut (.clk(clk), .rst_b(rst_b), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .tx_data(tx_data), .tx_valid(tx_valid),
    .tx_last(tx_last), .tx_ready(tx_ready), .rx_data(rx_data), .rx_valid(rx_valid),
    .rx_last(rx_last));
  mec_peer peer (.clk(clk), .jam(jam), .tx_ready(tx_ready), .rx_data(rx_data),
    .rx_valid(rx_valid), .rx_last(rx_last));
  // 250 MHz clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Random sink stalls, about one cycle in three
  always @(posedge clk) begin
    jam <= slow && ($random(seed) % 3 == 0);
  end
  task wrap_up;
    begin
      if (failures == 0 && comparisons > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  task chk(input [31:0] e, input [31:0] g);
    begin
      comparisons = comparisons + 1;
      if (e !== g) begin
        failures = failures + 1;
        $display("[FAIL] t=%0t exp=%h got=%h", $time, e, g);
      end
    end
  endtask
  // Pair each result at the ports with the oldest note; a stray octet meets an unknown
  always @(posedge clk) begin
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && rd_q.size() > 0)
      chk(rd_q.pop_front(), wb_dat_o);
    if (tx_valid === 1'b1 && tx_ready === 1'b1)
      chk(tx_q.size() > 0 ? {23'h0, tx_q.pop_front()} : 32'hx, {23'h0, tx_last, tx_data});
  end
  // One classic cycle held until acknowledge, then released for a cycle
  task bus(input w, input [7:0] a, input [31:0] d, input [3:0] s, output [31:0] v);
    begin
      @(posedge clk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_dat_i <= d;
      wb_sel_i <= s;
      @(posedge clk);
      while (wb_ack_o !== 1'b1)
        @(posedge clk);
      v = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
    end
  endtask
  task wr(input [7:0] a, input [31:0] d);
    bus(1'b1, a, d, 4'hf, q);
  endtask
  task rd(input [7:0] a, input [31:0] e);
    begin
      rd_q.push_back(e);
      bus(1'b0, a, 32'h0, 4'hf, q);
    end
  endtask
  task ex(input [7:0] d, input l);
    tx_q.push_back({l, d});
  endtask
  // Start when idle, then wait until every noted octet has left
  task go(input [1:0] k);
    begin
      do bus(1'b0, `MEC_R_CTRL, 32'h0, 4'hf, q); while (q[2] !== 1'b0);
      wr(`MEC_R_CTRL, {29'h0, k, 1'b1});
      while (tx_q.size() > 0)
        @(posedge clk);
    end
  endtask
  // Hang guard, far above the few hundred cycles the run needs
  initial begin
    repeat (20000) @(posedge clk);
    failures = failures + 1;
    wrap_up;
  end
  initial begin
    rst_b = 1'b0;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 8'h00;
    wb_dat_i = 32'h0;
    wb_sel_i = 4'h0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    rd(`MEC_R_CTRL, 32'h0);
    rd(`MEC_R_TXF1, 32'h1);
    wr(8'h3c, 32'hffffffff);
    rd(8'h3c, 32'h0);
    // Received elements: good switch, bad-length bonding, empty-channel report
    r = $random(seed);
    peer.send_switch(r[7:0], r[15:8], r[31:16]);
    rd(`MEC_R_RXF0, r);
    rd(`MEC_R_CTRL, 32'h08);
    wr(`MEC_R_CTRL, 32'h08);
    peer.put(`MEC_ID_BOND, 1'b0);
    peer.put(8'h04, 1'b0);
    for (i = 0; i < 3; i++)
      peer.put(r[7:0], i == 2);
    rd(`MEC_R_CTRL, 32'h58);
    wr(`MEC_R_CTRL, 32'h08);
    peer.send_meas0(r[7:0], r[11:8]);
    rd(`MEC_R_CTRL, 32'hc8);
    rd(`MEC_R_RXF1, {21'h0, 3'h1, r[7:0]});
    wr(`MEC_R_RXLVL, 32'h0);
    rd(`MEC_R_RXLVL, {28'h0, r[11:8]});
    wr(`MEC_R_CTRL, 32'h08);
    // Switch element sent into a stalling peer
    slow <= 1'b1;
    r = $random(seed);
    wr(`MEC_R_TXF0, r);
    ex(`MEC_ID_SWITCH, 1'b0);
    ex(`MEC_LEN_SWITCH, 1'b0);
    ex(r[7:0], 1'b0);
    ex(r[15:8], 1'b0);
    ex(r[23:16], 1'b0);
    ex(r[31:24], 1'b1);
    go(`MEC_K_SWITCH);
    // Bonding with every reason code; a partial write must not land
    for (i = 0; i < 4; i++) begin
      slow <= i[0];
      r = $random(seed);
      r[18:17] = i[1:0];
      r[16] = i[0];
      wr(`MEC_R_TXF0, r);
      bus(1'b1, `MEC_R_TXF0, ~r, 4'h7, q);
      ex(`MEC_ID_BOND, 1'b0);
      ex(`MEC_LEN_BOND, 1'b0);
      ex(r[7:0], 1'b0);
      ex(r[15:8], 1'b0);
      ex({r[16], 1'b0, r[18:17], r[22:19]}, 1'b1);
      go(`MEC_K_BOND);
    end
    // Channel change with the zero countdown of discovery frames
    r = $random(seed);
    r[7:0] = 8'h00;
    wr(`MEC_R_TXF0, r);
    ex(`MEC_ID_CHCHG, 1'b0);
    ex(`MEC_LEN_CHCHG, 1'b0);
    ex(8'h00, 1'b0);
    ex(r[15:8], 1'b1);
    go(`MEC_K_CHCHG);
    // Measurement: three levels in zone 15 with padding, then an empty-map report
    r = $random(seed);
    wr(`MEC_R_TXF1, {21'h0, 3'h2, r[23:16]});
    wr(`MEC_R_REPSEL, 32'h0);
    wr(`MEC_R_REPBMP, 32'h80058000);
    rd(`MEC_R_REPBMP, 32'h80058000);
    wr(`MEC_R_REPSEL, 32'h1);
    wr(`MEC_R_REPBMP, 32'h0);
    for (i = 0; i < 4; i++)
      wr(`MEC_R_LVLWR, {i[27:0], r[i*4 +: 4]});
    ex(`MEC_ID_MEAS, 1'b0);
    ex(8'h0d, 1'b0);
    ex(r[23:16], 1'b0);
    ex(8'h02, 1'b0);
    ex(8'h00, 1'b0);
    ex(8'h80, 1'b0);
    ex(8'h05, 1'b0);
    ex(8'h80, 1'b0);
    ex(r[7:0], 1'b0);
    ex({4'h0, r[11:8]}, 1'b0);
    for (i = 0; i < 4; i++)
      ex(8'h00, 1'b0);
    ex({4'h0, r[15:12]}, 1'b1);
    go(`MEC_K_MEAS);
    // Report counts of zero and above the maximum are refused
    for (i = 0; i < 2; i++) begin
      wr(`MEC_R_TXF1, {21'h0, i[0] ? 3'h5 : 3'h0, 8'h00});
      go(`MEC_K_MEAS);
      rd(`MEC_R_CTRL, 32'he0);
    end
    // Let the monitor compare the last read before the verdict
    @(posedge clk);
    wrap_up;
  end
endmodule
